//--- hdl/slw_defs.vh
`ifndef SLW_DEFS_VH
`define SLW_DEFS_VH

// width of the received signal level and of the threshold
`define SLW_LEVEL_W 16
// threshold after reset: 0 never warns until one is written or taught
`define SLW_THRESH_RESET 16'h0000
// polarity codes
`define SLW_POL_ACTIVE_LOW 1'h0
`define SLW_POL_ACTIVE_HIGH 1'h1
// switching function codes per output
`define SLW_FUNC_OFF 1'h0
`define SLW_FUNC_WARN 1'h1
// level that a disabled output sits at
`define SLW_OUT_IDLE 1'h0

`endif

//--- hdl/slw_channel.v
`include "slw_defs.vh"
`default_nettype none

// one switching output: working settings, teach capture, compare and drive
module slw_channel #(
  parameter LEVEL_W = `SLW_LEVEL_W
) (
  // clock and reset
  input wire clock,
  input wire rst,
  // measurement side
  input wire meas_valid,
  input wire [LEVEL_W-1:0] level,
  // staged settings, taken on a commit
  input wire commit,
  input wire stage_func,
  input wire stage_pol,
  input wire [LEVEL_W-1:0] stage_thresh,
  // teach request, already a one-cycle pulse
  input wire teach,
  // results
  output reg out_q,
  output reg warn_q,
  output reg [LEVEL_W-1:0] thresh_q,
  output reg func_q,
  output reg pol_q,
  output reg teach_done_q
);

  reg teach_pend_q;
  wire below;

  // single threshold, no hysteresis
  assign below = (level < thresh_q);

  always @(posedge clock) begin
    if (rst) begin
      thresh_q <= `SLW_THRESH_RESET;
      func_q <= `SLW_FUNC_OFF;
      pol_q <= `SLW_POL_ACTIVE_LOW;
      teach_pend_q <= 1'h0;
      teach_done_q <= 1'h0;
      warn_q <= 1'h0;
      out_q <= `SLW_OUT_IDLE;
    end else begin
      teach_done_q <= 1'h0;
      if (commit) begin
        // new settings wait for the next measurement
        func_q <= stage_func;
        pol_q <= stage_pol;
        thresh_q <= stage_thresh;
      end
      if (meas_valid) begin
        if (teach_pend_q && (func_q == `SLW_FUNC_WARN)) begin
          // capture the level of the reference object
          thresh_q <= level;
          teach_pend_q <= 1'h0;
          teach_done_q <= 1'h1;
        end
        // one evaluation per measurement, held in between
        warn_q <= below & (func_q == `SLW_FUNC_WARN);
        if (func_q == `SLW_FUNC_WARN) begin
          out_q <= (pol_q == `SLW_POL_ACTIVE_HIGH) ? below : ~below;
        end else begin
          out_q <= `SLW_OUT_IDLE;
        end
      end
      // a request that meets a capture stays pending, so no teach is lost
      if (teach) begin
        teach_pend_q <= 1'h1;
      end
    end
  end

endmodule // slw_channel

`default_nettype wire

//--- hdl/slw_warning.v
`include "slw_defs.vh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - each of the two switching outputs may select the level warning function
// - output active while received level is below threshold, inactive otherwise
// - per-output polarity chooses active high or active low
// - threshold is written as any unsigned value from 0 to 65535
// - teach captures the current received level as the threshold of an output set to the warning function
// - no hysteresis: one threshold for both transitions
module slw_warning #(
  parameter LEVEL_W = `SLW_LEVEL_W
) (
  // clock and reset
  input wire clock,
  input wire rst,
  // measurement engine, same clock
  input wire meas_valid,
  input wire [LEVEL_W-1:0] received_level,
  // staged configuration, first output
  input wire first_func_sel,
  input wire first_pol_high,
  input wire [LEVEL_W-1:0] first_thresh,
  // staged configuration, second output
  input wire second_func_sel,
  input wire second_pol_high,
  input wire [LEVEL_W-1:0] second_thresh,
  // write-all strobe, same clock, one-cycle pulse
  input wire write_all,
  // teach request pins, asynchronous levels
  input wire first_teach_pin,
  input wire second_teach_pin,
  // switching outputs
  output wire first_switching_output,
  output wire second_switching_output,
  // status
  output wire [1:0] received_level_warning,
  output wire [LEVEL_W-1:0] first_thresh_active,
  output wire [LEVEL_W-1:0] second_thresh_active,
  output wire [1:0] teach_done
);

  // number of switching outputs served by this block
  localparam NUM_OUT = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // staged settings and teach pins, gathered per output

  wire [NUM_OUT-1:0] stage_func;
  wire [NUM_OUT-1:0] stage_pol;
  wire [NUM_OUT*LEVEL_W-1:0] stage_thresh;
  wire [NUM_OUT-1:0] teach_pin;

  assign stage_func[0] = first_func_sel;
  assign stage_func[1] = second_func_sel;
  assign stage_pol[0] = first_pol_high;
  assign stage_pol[1] = second_pol_high;
  assign stage_thresh[LEVEL_W-1:0] = first_thresh;
  assign stage_thresh[2*LEVEL_W-1:LEVEL_W] = second_thresh;
  assign teach_pin[0] = first_teach_pin;
  assign teach_pin[1] = second_teach_pin;

  ////////////////////////////////////////////////////////////////////////////////
  // per-output results, one lane per switching output

  wire [NUM_OUT-1:0] teach_pulse;
  wire [NUM_OUT-1:0] out_w;
  wire [NUM_OUT-1:0] warn_w;
  wire [NUM_OUT-1:0] done_w;
  wire [NUM_OUT*LEVEL_W-1:0] thresh_w;

  ////////////////////////////////////////////////////////////////////////////////
  // one slice per switching output, independent of the other

  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g = g + 1) begin : g_ch
      // two flops cross the pin in; the third holds the previous level for the edge
      reg sync_a_q;
      reg sync_b_q;
      reg sync_prev_q;

      always @(posedge clock) begin
        if (rst) begin
          sync_a_q <= 1'h0;
          sync_b_q <= 1'h0;
          sync_prev_q <= 1'h0;
        end else begin
          sync_a_q <= teach_pin[g];
          sync_b_q <= sync_a_q;
          sync_prev_q <= sync_b_q;
        end
      end

      // reset level equals the idle pin level, so no teach follows reset
      assign teach_pulse[g] = sync_b_q & ~sync_prev_q;

      slw_channel #(
        .LEVEL_W(LEVEL_W)
      ) u_ch (
        .clock(clock),
        .rst(rst),
        .meas_valid(meas_valid),
        .level(received_level),
        .commit(write_all),
        .stage_func(stage_func[g]),
        .stage_pol(stage_pol[g]),
        .stage_thresh(stage_thresh[g*LEVEL_W +: LEVEL_W]),
        .teach(teach_pulse[g]),
        .out_q(out_w[g]),
        .warn_q(warn_w[g]),
        .thresh_q(thresh_w[g*LEVEL_W +: LEVEL_W]),
        .func_q(),
        .pol_q(),
        .teach_done_q(done_w[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // lanes back to the named ports

  assign first_switching_output = out_w[0];
  assign second_switching_output = out_w[1];
  assign received_level_warning = warn_w;
  assign teach_done = done_w;
  assign first_thresh_active = thresh_w[LEVEL_W-1:0];
  assign second_thresh_active = thresh_w[2*LEVEL_W-1:LEVEL_W];

endmodule // slw_warning

`default_nettype wire

//--- tb/slw_ctl_model.sv
`default_nettype none
// control system: accepts an output level only after it held two cycles
module slw_ctl_model (
  input wire logic clock,
  input wire logic [1:0] sw,
  output logic [1:0] seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] last_q;
  always @(posedge clock) begin
    last_q <= sw;
    if (last_q == sw) seen <= sw;
  end
endmodule // slw_ctl_model
`default_nettype wire

//--- tb/slw_warning_asserts.sv
`default_nettype none
module slw_warning_asserts #(parameter int LEVEL_W = 16) (
  input wire logic clock, rst, meas_valid, write_all,
  input wire logic [LEVEL_W-1:0] received_level, first_thresh, second_thresh,
  input wire logic first_switching_output, second_switching_output,
  input wire logic [1:0] received_level_warning, teach_done,
  input wire logic [LEVEL_W-1:0] first_thresh_active, second_thresh_active
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_above_one: assert property (
    meas_valid && received_level >= first_thresh_active |=> !received_level_warning[0])
    else $error("warn above threshold");
  a_above_two: assert property (
    meas_valid && received_level >= second_thresh_active |=> !received_level_warning[1])
    else $error("warn above threshold");
  a_warn_hold: assert property (
    !meas_valid |=> $stable(received_level_warning)) else $error("warn moved");
  a_out_hold: assert property (
    !meas_valid |=> $stable({first_switching_output, second_switching_output}))
    else $error("output moved");
  a_write_one: assert property (
    write_all && !meas_valid |=> first_thresh_active == $past(first_thresh))
    else $error("threshold not taken");
  a_write_two: assert property (
    write_all && !meas_valid |=> second_thresh_active == $past(second_thresh))
    else $error("threshold not taken");
  a_thr_keep: assert property (
    !write_all && !meas_valid |=> $stable(first_thresh_active)) else $error("threshold moved");
  a_teach_val: assert property (
    teach_done[0] |-> first_thresh_active == $past(received_level)) else $error("bad teach");
  a_teach_two: assert property (
    teach_done[1] |-> second_thresh_active == $past(received_level)) else $error("bad teach");
  cover property (teach_done[0]);
  cover property (teach_done[1]);
  cover property (received_level_warning == 2'h3);
  cover property (second_switching_output);
endmodule // slw_warning_asserts
bind slw_warning slw_warning_asserts #(.LEVEL_W(LEVEL_W)) slw_warning_asserts_inst (.*);
`default_nettype wire

//--- tb/slw_warning_tb_top.sv
`default_nettype none
module slw_warning_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rst = 1, meas_valid = 0, write_all = 0, first_func_sel = 0;
  logic first_pol_high = 0, second_func_sel = 0, second_pol_high = 0;
  logic first_teach_pin = 0, second_teach_pin = 0;
  logic [15:0] received_level = 0, first_thresh = 0, second_thresh = 0;
  logic first_switching_output, second_switching_output;
  logic [1:0] received_level_warning, teach_done, seen;
  logic [15:0] first_thresh_active, second_thresh_active;
  int err_count = 0, check_count = 0;
  logic [1:0] done_seen;
  always @(posedge clock) begin
    if (rst) done_seen <= 2'h0;
    else done_seen <= done_seen | teach_done;
  end
  slw_warning slw_warning_inst (.*);
  slw_ctl_model slw_ctl_model_inst (.clock(clock), .sw({second_switching_output,
    first_switching_output}), .seen(seen));
  task automatic chk(input logic [15:0] got, exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cfg(input logic f1, p1, f2, p2, input logic [15:0] t1);
    @(posedge clock);
    {first_func_sel, first_pol_high, second_func_sel, second_pol_high} <= {f1, p1, f2, p2};
    first_thresh <= t1;
    second_thresh <= 16'hffff;
    write_all <= 1;
    @(posedge clock);
    write_all <= 0;
    @(posedge clock);
    #1 chk(first_thresh_active, t1);
  endtask
  // exp is {second out, first out, warning bits}
  task automatic meas(input logic [15:0] l, input logic [3:0] exp);
    @(posedge clock);
    meas_valid <= 1;
    received_level <= l;
    @(posedge clock);
    meas_valid <= 0;
    repeat (3) @(posedge clock);
    #1 chk({second_switching_output, first_switching_output, received_level_warning}, exp);
    chk(seen, exp[3:2]);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial forever #2 clock = ~clock;
  initial begin
    #20000;
    err_count++;
    give_verdict;
  end
  initial begin
    repeat (3) @(posedge clock);
    rst <= 0;
    cfg(1, 1, 1, 0, 16'h0064);
    chk(second_thresh_active, 16'hffff);
    meas(16'h0032, 4'h7);
    meas(16'h0064, 4'h2);
    meas(16'h0063, 4'h7);
    meas(16'hffff, 4'h8);
    @(posedge clock);
    first_thresh <= 16'h0000;
    meas(16'h0032, 4'h7);
    @(posedge clock);
    first_teach_pin <= 1;
    repeat (3) @(posedge clock);
    meas(16'h04d2, 4'h2);
    chk(first_thresh_active, 16'h04d2);
    @(posedge clock);
    first_teach_pin <= 0;
    cfg(1, 1, 1, 0, 16'h03db);
    meas(16'h03da, 4'h7);
    cfg(0, 1, 1, 0, 16'h03db);
    meas(16'h0000, 4'h2);
    @(posedge clock);
    {second_teach_pin, first_teach_pin} <= 2'h3;
    repeat (3) @(posedge clock);
    meas(16'h0100, 4'h2);
    chk(second_thresh_active, 16'h0100);
    chk(first_thresh_active, 16'h03db);
    chk(done_seen, 2'h3);
    give_verdict;
  end
endmodule // slw_warning_tb_top
`default_nettype wire
